/* common/tfb_pkg.sv */
// constants for the temperature fault and fan boost block
// assumes one 125 MHz clock domain and synchronous inputs
package tfb_pkg;
  localparam int TEMP_W = 8;
  localparam int NZONE = 4;
  localparam int NDIODE = 4;
  localparam int NTACH = 4;
  localparam int TACH_W = 16;
  localparam logic [7:0] TEMP_MASK_CODE = 8'h80;
  localparam logic [7:0] BOOST_LIM_RST_HI = 8'h3C;
  localparam logic [7:0] BOOST_LIM_RST_LO = 8'h23;
  localparam logic [7:0] FRAC9_HALF = 8'h80;
  localparam int FRAC12_POS = 4;
  localparam logic [3:0] FRAC12_ZERO = 4'h0;
  localparam int CLK_MHZ = 125;
  localparam int TIMEOUT_TICK_US = 1000;
  localparam int TIMEOUT_TICK_CYC = TIMEOUT_TICK_US * CLK_MHZ;
  localparam int TO_SEL_W = 4;
  typedef enum logic [1:0] {TFB_TB_IDLE, TFB_TB_ERR, TFB_TB_HOLD} tfb_tach_st_t;
endpackage

/* core/tfb_tach_boost.sv */
// one tachometer error boost channel with hold-off timer
// assumes synchronous inputs and a released reset copy
`timescale 1ns/1ps
module tfb_tach_boost #(
  parameter int TICK_CYC = tfb_pkg::TIMEOUT_TICK_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic err_evt,
  input wire logic enable,
  input wire logic [tfb_pkg::TO_SEL_W-1:0] timeout_ticks,
  output logic boost
);
  tfb_pkg::tfb_tach_st_t st_reg;
  logic [31:0] tick_cnt_reg;
  logic [tfb_pkg::TO_SEL_W-1:0] left_reg;
  logic tick;

  // refused at elaboration: a zero tick would never end a hold
  if (TICK_CYC < 1)
  begin : g_bad_tick
    $error("tick count must be at least one cycle");
  end

  assign tick = (tick_cnt_reg == 32'(TICK_CYC - 1));

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      tick_cnt_reg <= 32'h0000_0000;
    else if (st_reg != tfb_pkg::TFB_TB_HOLD || tick)
      tick_cnt_reg <= 32'h0000_0000;
    else
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= tfb_pkg::TFB_TB_IDLE;
      left_reg <= '0;
    end
    else if (!enable)
      st_reg <= tfb_pkg::TFB_TB_IDLE;
    else
    begin
      case (st_reg)
        tfb_pkg::TFB_TB_IDLE:
          if (err_evt)
            st_reg <= tfb_pkg::TFB_TB_ERR;
        tfb_pkg::TFB_TB_ERR:
          if (!err_evt)
          begin
            // full interval loaded only once the error ends
            left_reg <= timeout_ticks;
            st_reg <= (timeout_ticks == '0) ? tfb_pkg::TFB_TB_IDLE : tfb_pkg::TFB_TB_HOLD;
          end
        tfb_pkg::TFB_TB_HOLD:
          if (err_evt)
            st_reg <= tfb_pkg::TFB_TB_ERR;
          else if (tick)
          begin
            left_reg <= left_reg - 4'h1;
            if (left_reg == 4'h1)
              st_reg <= tfb_pkg::TFB_TB_IDLE;
          end
        default:
          st_reg <= tfb_pkg::TFB_TB_IDLE;
      endcase
    end
  end

  assign boost = enable && (err_evt || st_reg != tfb_pkg::TFB_TB_IDLE);
endmodule

/* core/tfb_top.sv */
// temperature encoding, diode fault flags and fan boost override
// assumes conversion strobes and limits come from surrounding register logic
`timescale 1ns/1ps
// Notes on behaviour
// - plain temperatures, limits and config temperatures are signed bytes, one degree per count
// - a limit of 80h masks its channel; no limit error raised
// - unfiltered extended result: whole degrees high byte, half degree in low bit 7
// - filtered extended result: sixteenths in low byte upper nibble, lower nibble zero
// - four-bit fan configuration fields are unsigned
// - each diode is checked for open or short before result update; sets status
// - faulted diode loads 80h into its result
// - any zone above its boost limit makes a temperature boost
// - temperature boost drives both fan outputs full on
// - zone boost holds until temperature at or below limit minus hysteresis
// - boost limits reset to 60 C for zones 1,2 and 35 C for 3,4
// - tach boost only when enabled and error unmasked
// - tach error exists while count exceeds its limit
// - tach boost drives bound output a, b or both to full duty
// - after tach error ends, boost holds for programmed timeout
// - error returning during timeout restarts a full interval after it ends
// - error flags kept in two mirrored status sets, cleared independently
module tfb_top #(
  parameter int TICK_CYC = tfb_pkg::TIMEOUT_TICK_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [tfb_pkg::NDIODE-1:0] diode_conv_done,
  input wire logic [tfb_pkg::NDIODE-1:0] diode_open,
  input wire logic [tfb_pkg::NDIODE-1:0] diode_short,
  input wire logic [tfb_pkg::NDIODE*12-1:0] diode_raw_q4,
  input wire logic [tfb_pkg::NDIODE*12-1:0] diode_filt_q4,
  input wire logic [tfb_pkg::NDIODE*8-1:0] temp_limit,
  input wire logic [tfb_pkg::NZONE*8-1:0] zone_temp,
  input wire logic [tfb_pkg::NZONE-1:0] boost_limit_wr,
  input wire logic [7:0] boost_limit_wdata,
  input wire logic [3:0] boost_hyst,
  input wire logic [tfb_pkg::NTACH*tfb_pkg::TACH_W-1:0] tach_count,
  input wire logic [tfb_pkg::NTACH*tfb_pkg::TACH_W-1:0] tach_limit,
  input wire logic [tfb_pkg::NTACH-1:0] tach_err_mask,
  input wire logic tach_boost_en,
  input wire logic [3:0] tach_boost_timeout,
  input wire logic [tfb_pkg::NTACH-1:0] tach_bind_a,
  input wire logic [tfb_pkg::NTACH-1:0] tach_bind_b,
  input wire logic [7:0] duty_normal_a,
  input wire logic [7:0] duty_normal_b,
  input wire logic [tfb_pkg::NDIODE*3-1:0] status_clr_bmc,
  input wire logic [tfb_pkg::NDIODE*3-1:0] status_clr_host,
  output logic [tfb_pkg::NDIODE*8-1:0] temp_result,
  output logic [tfb_pkg::NDIODE*16-1:0] temp_ext9,
  output logic [tfb_pkg::NDIODE*16-1:0] temp_ext12,
  output logic [tfb_pkg::NDIODE*3-1:0] status_bmc,
  output logic [tfb_pkg::NDIODE*3-1:0] status_host,
  output logic [tfb_pkg::NZONE*8-1:0] boost_limit_q,
  output logic [tfb_pkg::NZONE-1:0] zone_boost_q,
  output logic [tfb_pkg::NTACH-1:0] tach_err_q,
  output logic [7:0] fan_drive_out_a,
  output logic [7:0] fan_drive_out_b
);
  logic rst_sync1_reg;
  logic rst_sync2_reg;
  logic rstn;
  logic [tfb_pkg::NZONE-1:0] zone_boost_reg;
  logic [tfb_pkg::NTACH-1:0] tach_err_reg;
  logic [tfb_pkg::NTACH-1:0] tach_boost;
  logic temp_boost;
  logic boost_a;
  logic boost_b;

  if (TICK_CYC < 1)
  begin : g_bad_tick
    $error("TICK_CYC must be positive");
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end
    else
    begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end
  assign rstn = rst_sync2_reg;

  // per-diode result encoding and fault status; status bits: 0 open, 1 short, 2 limit
  genvar gi;
  generate
    for (gi = 0; gi < tfb_pkg::NDIODE; gi++)
    begin : g_diode
      logic [11:0] raw;
      logic [11:0] filt;
      logic [7:0] lim;
      logic fault;
      logic over;
      logic [2:0] evt;
      assign raw = diode_raw_q4[gi*12 +: 12];
      assign filt = diode_filt_q4[gi*12 +: 12];
      assign lim = temp_limit[gi*8 +: 8];
      assign fault = diode_open[gi] | diode_short[gi];
      // masked channel never flags a limit
      assign over = (lim != tfb_pkg::TEMP_MASK_CODE) && ($signed(raw[11:4]) > $signed(lim));
      assign evt = diode_conv_done[gi] ? {over & ~fault, diode_short[gi], diode_open[gi]} : 3'h0;

      always_ff @(posedge clk_sys or negedge rstn)
      begin
        if (!rstn)
        begin
          temp_result[gi*8 +: 8] <= 8'h00;
          temp_ext9[gi*16 +: 16] <= 16'h0000;
          temp_ext12[gi*16 +: 16] <= 16'h0000;
        end
        else if (diode_conv_done[gi])
        begin
          if (fault)
          begin
            temp_result[gi*8 +: 8] <= tfb_pkg::TEMP_MASK_CODE;
            temp_ext9[gi*16 +: 16] <= {tfb_pkg::TEMP_MASK_CODE, 8'h00};
            temp_ext12[gi*16 +: 16] <= {tfb_pkg::TEMP_MASK_CODE, 8'h00};
          end
          else
          begin
            temp_result[gi*8 +: 8] <= raw[11:4];
            // truncation toward minus infinity keeps the two's complement grid
            temp_ext9[gi*16 +: 16] <= {raw[11:4], raw[3] ? tfb_pkg::FRAC9_HALF : 8'h00};
            temp_ext12[gi*16 +: 16] <= {filt[11:4], filt[3:0], tfb_pkg::FRAC12_ZERO};
          end
        end
      end

      // set beats clear in each mirrored set
      always_ff @(posedge clk_sys or negedge rstn)
      begin
        if (!rstn)
        begin
          status_bmc[gi*3 +: 3] <= 3'h0;
          status_host[gi*3 +: 3] <= 3'h0;
        end
        else
        begin
          status_bmc[gi*3 +: 3] <= (status_bmc[gi*3 +: 3] & ~status_clr_bmc[gi*3 +: 3]) | evt;
          status_host[gi*3 +: 3] <= (status_host[gi*3 +: 3] & ~status_clr_host[gi*3 +: 3]) | evt;
        end
      end
    end
  endgenerate

  // zone boost with hysteresis
  generate
    for (gi = 0; gi < tfb_pkg::NZONE; gi++)
    begin : g_zone
      logic signed [9:0] t;
      logic signed [9:0] lim;
      logic signed [9:0] rel;
      assign t = 10'(signed'(zone_temp[gi*8 +: 8]));
      assign lim = 10'(signed'(boost_limit_q[gi*8 +: 8]));
      assign rel = lim - 10'(boost_hyst);

      always_ff @(posedge clk_sys or negedge rstn)
      begin
        if (!rstn)
          boost_limit_q[gi*8 +: 8] <= (gi < 2) ? tfb_pkg::BOOST_LIM_RST_HI : tfb_pkg::BOOST_LIM_RST_LO;
        else if (boost_limit_wr[gi])
          boost_limit_q[gi*8 +: 8] <= boost_limit_wdata;
      end

      always_ff @(posedge clk_sys or negedge rstn)
      begin
        if (!rstn)
          zone_boost_reg[gi] <= 1'b0;
        else if (t > lim)
          zone_boost_reg[gi] <= 1'b1;
        else if (t <= rel)
          zone_boost_reg[gi] <= 1'b0;
      end
    end
  endgenerate

  // tach error detection and per-tach boost channel
  generate
    for (gi = 0; gi < tfb_pkg::NTACH; gi++)
    begin : g_tach
      always_ff @(posedge clk_sys or negedge rstn)
      begin
        if (!rstn)
          tach_err_reg[gi] <= 1'b0;
        else
          tach_err_reg[gi] <= tach_count[gi*tfb_pkg::TACH_W +: tfb_pkg::TACH_W]
            > tach_limit[gi*tfb_pkg::TACH_W +: tfb_pkg::TACH_W];
      end

      tfb_tach_boost #(
        .TICK_CYC(TICK_CYC)
      ) u_tb (
        .clk_sys(clk_sys),
        .rst_n(rstn),
        .err_evt(tach_err_reg[gi] & ~tach_err_mask[gi]),
        .enable(tach_boost_en),
        .timeout_ticks(tach_boost_timeout),
        .boost(tach_boost[gi])
      );
    end
  endgenerate

  assign temp_boost = |zone_boost_reg;
  assign boost_a = temp_boost | (|(tach_boost & tach_bind_a));
  assign boost_b = temp_boost | (|(tach_boost & tach_bind_b));

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      fan_drive_out_a <= 8'h00;
      fan_drive_out_b <= 8'h00;
      zone_boost_q <= '0;
      tach_err_q <= '0;
    end
    else
    begin
      fan_drive_out_a <= boost_a ? 8'hFF : duty_normal_a;
      fan_drive_out_b <= boost_b ? 8'hFF : duty_normal_b;
      zone_boost_q <= zone_boost_reg;
      tach_err_q <= tach_err_reg;
    end
  end
endmodule

/* dv/tfb_fan_model.sv */
// behavioural fan on one drive output
// assumes ffh duty means full speed
`timescale 1ns/1ps
module tfb_fan_model (
  input wire logic clk_sys,
  input wire logic [7:0] duty,
  output logic full_on
);
  // a fan reacts to the drive one edge late
  always_ff @(posedge clk_sys)
  begin
    full_on <= (duty == 8'hFF);
  end
endmodule

/* dv/tfb_top_chk.sv */
// port assertions for the temperature fault and fan boost block
// assumes channel 0 traffic from the bench
`timescale 1ns/1ps
module tfb_top_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [3:0] diode_conv_done,
  input wire logic [3:0] diode_open,
  input wire logic [3:0] diode_short,
  input wire logic [47:0] diode_raw_q4,
  input wire logic [3:0] tach_err_mask,
  input wire logic tach_boost_en,
  input wire logic [3:0] tach_bind_a,
  input wire logic [7:0] duty_normal_a,
  input logic [31:0] temp_result,
  input logic [63:0] temp_ext9,
  input logic [63:0] temp_ext12,
  input logic [11:0] status_bmc,
  input logic [11:0] status_host,
  input logic [31:0] boost_limit_q,
  input logic [3:0] zone_boost_q,
  input logic [3:0] tach_err_q,
  input logic [7:0] fan_drive_out_a,
  input logic [7:0] fan_drive_out_b
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_good;
    diode_conv_done[0] && !diode_open[0] && !diode_short[0];
  endsequence
  // six quiet edges cover the internal reset release
  sequence s_calm;
    (zone_boost_q == 4'h0 && !tach_boost_en)[*6];
  endsequence
  fault_load_a: assert property (diode_conv_done[0] && (diode_open[0] || diode_short[0]) |=>
    temp_result[7:0] == 8'h80) else $error("fault result not 80h");
  byte_load_a: assert property (s_good |=> temp_result[7:0] == $past(diode_raw_q4[11:4]) &&
    temp_ext9[15:0] == {$past(diode_raw_q4[11:3]), 7'h00}) else $error("result format wrong");
  frac_zero_a: assert property (temp_ext12[3:0] == 4'h0) else $error("ext12 low nibble set");
  fault_flag_a: assert property (diode_conv_done[0] && diode_open[0] |=>
    status_bmc[0] && status_host[0]) else $error("open flag missing");
  lim_reset_a: assert property ($rose(rst_n) |-> boost_limit_q == 32'h23233C3C)
    else $error("boost limit reset wrong");
  zone_full_a: assert property (zone_boost_q != 4'h0 |-> ##[0:1]
    (fan_drive_out_a == 8'hFF && fan_drive_out_b == 8'hFF)) else $error("zone boost not full");
  tach_full_a: assert property (tach_err_q[0] && !tach_err_mask[0] && tach_boost_en && tach_bind_a[0]
    |-> ##[0:2] fan_drive_out_a == 8'hFF) else $error("tach boost not full");
  // output lags the duty input by one register stage
  normal_duty_a: assert property (s_calm |-> fan_drive_out_a == $past(duty_normal_a))
    else $error("normal duty not restored");
endmodule
bind tfb_top tfb_top_chk u_chk (
  .clk_sys(clk_sys),
  .rst_n(rst_n),
  .diode_conv_done(diode_conv_done),
  .diode_open(diode_open),
  .diode_short(diode_short),
  .diode_raw_q4(diode_raw_q4),
  .tach_err_mask(tach_err_mask),
  .tach_boost_en(tach_boost_en),
  .tach_bind_a(tach_bind_a),
  .duty_normal_a(duty_normal_a),
  .temp_result(temp_result),
  .temp_ext9(temp_ext9),
  .temp_ext12(temp_ext12),
  .status_bmc(status_bmc),
  .status_host(status_host),
  .boost_limit_q(boost_limit_q),
  .zone_boost_q(zone_boost_q),
  .tach_err_q(tach_err_q),
  .fan_drive_out_a(fan_drive_out_a),
  .fan_drive_out_b(fan_drive_out_b)
);

/* dv/tfb_top_tb.sv */
// self-checking bench for tfb_top with two fan models
// assumes TICK_CYC of 4 so timeouts stay short
`timescale 1ns/1ps
module tfb_top_tb;
  logic clk_sys, rst_n, ten, full_a, full_b;
  logic [3:0] conv, dopen, dshort, lwr, hyst, mask, bind_a, bind_b, tto, zb, terr;
  logic [47:0] raw, filt;
  logic [31:0] tlim, ztemp, res, blim;
  logic [7:0] lwd, fa, fb, dna, dnb;
  logic [63:0] tcnt, tlimit, ext9, ext12;
  logic [11:0] clr_b, clr_h, st_b, st_h;
  int failures, compares, n;
  tfb_top #(.TICK_CYC(4)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .diode_conv_done(conv), .diode_open(dopen),
    .diode_short(dshort), .diode_raw_q4(raw), .diode_filt_q4(filt), .temp_limit(tlim), .zone_temp(ztemp),
    .boost_limit_wr(lwr), .boost_limit_wdata(lwd), .boost_hyst(hyst), .tach_count(tcnt), .tach_limit(tlimit),
    .tach_err_mask(mask), .tach_boost_en(ten), .tach_boost_timeout(tto), .tach_bind_a(bind_a),
    .tach_bind_b(bind_b), .duty_normal_a(dna), .duty_normal_b(dnb), .status_clr_bmc(clr_b),
    .status_clr_host(clr_h), .temp_result(res), .temp_ext9(ext9), .temp_ext12(ext12), .status_bmc(st_b),
    .status_host(st_h), .boost_limit_q(blim), .zone_boost_q(zb), .tach_err_q(terr), .fan_drive_out_a(fa),
    .fan_drive_out_b(fb));
  tfb_fan_model u_fan_a (.clk_sys(clk_sys), .duty(fa), .full_on(full_a));
  tfb_fan_model u_fan_b (.clk_sys(clk_sys), .duty(fb), .full_on(full_b));
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_sys);
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic t_conv();
    raw = 48'h7F07F0FF8198;
    filt = 48'h000000FFF7D1;
    tlim = 32'h00008010;
    dopen = 4'h4;
    dshort = 4'h8;
    conv = 4'hF;
    cyc(1);
    conv = 4'h0;
    cyc(1);
    chk("result d0 d1", 16'hFF19, res[15:0]);
    chk("result d2 d3", 16'h8080, res[31:16]);
    chk("ext9 d0", 16'h1980, ext9[15:0]);
    chk("ext9 d1", 16'hFF80, ext9[31:16]);
    chk("ext12 d0", 16'h7D10, ext12[15:0]);
    chk("ext12 d1", 16'hFFF0, ext12[31:16]);
    chk("status bmc", 16'h0444, {4'h0, st_b});
    clr_b = 12'hFFF;
    cyc(1);
    clr_b = 12'h0;
    cyc(1);
    chk("status bmc", 16'h0000, {4'h0, st_b});
    chk("status host", 16'h0444, {4'h0, st_h});
    // open fault on channel 0 also feeds the checker's fault properties
    dopen = 4'h1;
    conv = 4'h1;
    cyc(1);
    conv = 4'h0;
    cyc(1);
    chk("result d0", 16'h0080, {8'h0, res[7:0]});
    chk("status bmc", 16'h0001, {4'h0, st_b});
    chk("status host", 16'h0445, {4'h0, st_h});
    dopen = 4'h0;
  endtask
  task automatic t_zone();
    chk("zone boost", 16'h0, {12'h0, zb});
    ztemp[7:0] = 8'h3D;
    cyc(3);
    chk("zone boost", 16'h1, {12'h0, zb});
    chk("fans", 16'hFFFF, {fa, fb});
    hyst = 4'hC;
    ztemp[7:0] = 8'h31;
    cyc(3);
    chk("fans", 16'hFFFF, {fa, fb});
    ztemp[7:0] = 8'h30;
    cyc(3);
    chk("fans", 16'h4020, {fa, fb});
    lwd = 8'hE0;
    lwr = 4'h2;
    cyc(1);
    lwr = 4'h0;
    cyc(3);
    chk("boost limit", 16'h00E0, {8'h0, blim[15:8]});
    chk("zone boost", 16'h2, {12'h0, zb});
    lwd = 8'h3C;
    lwr = 4'h2;
    cyc(1);
    lwr = 4'h0;
    cyc(8);
  endtask
  task automatic t_tach();
    ten = 1'b1;
    mask = 4'h1;
    tcnt[15:0] = 16'h0200;
    cyc(4);
    chk("tach error", 16'h1, {12'h0, terr});
    chk("fan a", 16'h40, {8'h0, fa});
    mask = 4'h0;
    cyc(3);
    chk("fans", 16'hFF20, {fa, fb});
    bind_b = 4'h1;
    cyc(3);
    chk("fans", 16'hFFFF, {fa, fb});
    chk("fan b model", 16'h0001, {15'h0, full_b});
    bind_b = 4'h0;
    tcnt[15:0] = 16'h0080;
    cyc(6);
    tcnt[15:0] = 16'h0200;
    cyc(4);
    tcnt[15:0] = 16'h0080;
    n = 0;
    while (full_a === 1'b1 && n < 40)
    begin
      n++;
      cyc(1);
    end
    // restarted hold of 3 ticks of 4 cycles, plus four stages of delay to the fan model
    chk("hold length", 16'h0010, n[15:0]);
    tcnt[15:0] = 16'h0200;
    ten = 1'b0;
    cyc(8);
    chk("fan a", 16'h40, {8'h0, fa});
    dna = 8'h55;
    cyc(2);
    chk("fan a", 16'h0055, {8'h0, fa});
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial
  begin
    #400000;
    failures++;
    stop_test();
  end
  initial
  begin
    {conv, dopen, dshort, lwr, lwd, mask, bind_b, ten, clr_b, clr_h, raw, filt, tlim, tcnt} = '0;
    {hyst, tto, bind_a} = {4'h4, 4'h3, 4'h1};
    ztemp = 32'hF0F0F0F0;
    {dna, dnb} = {8'h40, 8'h20};
    tlimit = 64'h0100010001000100;
    rst_n = 1'b0;
    cyc(2);
    rst_n = 1'b1;
    cyc(3);
    chk("boost limit", 16'h2323, blim[31:16]);
    chk("boost limit", 16'h3C3C, blim[15:0]);
    t_conv();
    t_zone();
    t_tach();
    stop_test();
  end
endmodule
